// *** inc/card_flags_pkg.sv ***
// Shared constants for the smart card serial status flag block.
package card_flags_pkg;
    // ****************************************
    // Register byte offsets on the APB bus.
    // ****************************************
    localparam logic [7:0] OFF_STATUS = 8'h00; // Serial status, card mode meaning.
    localparam logic [7:0] OFF_CONTROL = 8'h04; // Serial control register.
    localparam logic [7:0] OFF_CARD_MODE = 8'h08; // Card mode register.
    localparam logic [7:0] OFF_TX_DATA = 8'h0C; // Transmit holding register.
    localparam logic [7:0] OFF_RX_DATA = 8'h10; // Receive holding register.
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14; // Sticky event bits.
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18; // Event enables.

    // ****************************************
    // Field positions.
    // ****************************************
    localparam int BIT_TX_EMPTY = 7; // Transmit holding empty.
    localparam int BIT_RX_FULL = 6; // Receive holding full.
    localparam int BIT_OVERRUN = 5; // Overrun error.
    localparam int BIT_ERR_SIG = 4; // Error signal status.
    localparam int BIT_TE = 0; // Transmit enable in the control register.
    localparam int BIT_RE = 1; // Receive enable in the control register.
    localparam int BIT_CARD_MODE = 0; // Card mode select in the card mode register.

    // Flag index order used in the flag vector and the event register.
    localparam int IDX_TX_EMPTY = 3;
    localparam int IDX_RX_FULL = 2;
    localparam int IDX_OVERRUN = 1;
    localparam int IDX_ERR_SIG = 0;
    localparam int NUM_FLAGS = 4;

    // ****************************************
    // Reset values.
    // ****************************************
    localparam logic [3:0] FLAGS_RESET = 4'h8; // Only transmit empty starts set.
    localparam logic [1:0] CONTROL_RESET = 2'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // Depth of the pin synchroniser.
    localparam int SYNC_STAGES = 3;
endpackage

// *** core/card_status_flags.sv ***
// Smart card serial status flags with APB register access.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// - Card flag meaning only when card mode set
// - Tx empty resets 1, forced 1 without TE
// - Tx empty sets on holding-to-shift move
// - Tx empty cleared by read-one, write-zero
// - Tx empty cleared by DMA holding write
// - Rx full sets on clean reception, resets 0
// - Rx full cleared by read-one, write-zero
// - Rx full cleared by DMA holding read
// - Rx full kept when receive disabled
// - Overrun sets on reception while rx full
// - Overrun keeps old data, drops new
// - No reception start while overrun set
// - Overrun cleared by read-one, write-zero
// - Overrun kept when receive disabled
// - Error flag sets on sampled low signal
// - Error flag cleared by read-one, write-zero
// - Only zero writes clear status flags; ones ignored
module card_status_flags #(
    parameter int DATA_W = 8 // Character width.
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_shift_load,
    output logic [DATA_W-1:0] tx_data,
    input wire logic rx_done,
    input wire logic rx_ok,
    input wire logic [DATA_W-1:0] rx_shift_reg,
    output logic [DATA_W-1:0] rx_holding_reg,
    output logic rx_start_allow,
    input wire logic card_line,
    input wire logic err_sample,
    input wire logic dma_tx_wr,
    input wire logic [DATA_W-1:0] dma_tx_data,
    input wire logic dma_rx_rd,
    output logic tx_empty_irq,
    output logic rx_full_irq,
    output logic irq
);
    // ****************************************
    // Parameter checks.
    // ****************************************
    // The character must fit the low bits of one bus word.
    if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
        $error("DATA_W must lie between 1 and 32.");
    end

    // ****************************************
    // Register storage.
    // ****************************************
    logic [3:0] flags_q; // Status flags, ordered by the package indices.
    logic [3:0] flags_d; // Next flag values.
    logic [3:0] armed_q; // Flag was read as one since it was last set.
    logic [3:0] armed_d; // Next armed values.
    logic [1:0] control_q; // Receive and transmit enables.
    logic card_mode_q; // Card mode select.
    logic [DATA_W-1:0] tx_hold_q; // Transmit holding register.
    logic [DATA_W-1:0] rx_hold_q; // Receive holding register.
    logic [3:0] irq_stat_q; // Sticky event bits.
    logic [3:0] irq_stat_d; // Next sticky event bits.
    logic [3:0] irq_mask_q; // Event enables.
    logic [31:0] prdata_q; // Registered read data.
    logic pready_q; // Registered ready.
    logic pslverr_q; // Registered error answer.
    logic tx_irq_q; // Transmit request to the DMA unit.
    logic rx_irq_q; // Receive request to the DMA unit.
    logic irq_q; // Combined interrupt.
    logic rx_allow_q; // Reception permitted.
    localparam int SYNC_STAGES_W = card_flags_pkg::SYNC_STAGES; // Synchroniser depth.
    logic [SYNC_STAGES_W-1:0] line_sync_q; // Pin synchroniser chain.
    logic line_level_q; // Filtered line level.

    // ****************************************
    // Bus decode.
    // ****************************************
    // Setup phase of any transfer; the answer is prepared here.
    wire setup = psel & ~penable;
    // Completing access phase; all side effects happen here only.
    wire access_done = psel & penable & pready_q;
    wire wr_done = access_done & pwrite;
    wire rd_done = access_done & ~pwrite;
    wire sel_status = (paddr == card_flags_pkg::OFF_STATUS);
    wire sel_control = (paddr == card_flags_pkg::OFF_CONTROL);
    wire sel_card = (paddr == card_flags_pkg::OFF_CARD_MODE);
    wire sel_tx = (paddr == card_flags_pkg::OFF_TX_DATA);
    wire sel_rx = (paddr == card_flags_pkg::OFF_RX_DATA);
    wire sel_istat = (paddr == card_flags_pkg::OFF_IRQ_STATUS);
    wire sel_imask = (paddr == card_flags_pkg::OFF_IRQ_MASK);
    wire mapped = sel_status | sel_control | sel_card | sel_tx | sel_rx
                  | sel_istat | sel_imask;

    // Enables as seen by the flag logic.
    wire tx_en = control_q[card_flags_pkg::BIT_TE];
    wire rx_en = control_q[card_flags_pkg::BIT_RE];
    wire card_on = card_mode_q;

    // ****************************************
    // Flag events.
    // ****************************************
    // holding-to-shift move
    wire set_tx = card_on & tx_en & tx_shift_load;
    wire dma_tx_clr = card_on & dma_tx_wr & tx_irq_q;
    wire dma_rx_clr = card_on & dma_rx_rd & rx_irq_q;
    // A reception only counts while allowed; one during overrun is dropped.
    wire rx_ev = card_on & rx_done & rx_allow_q;
    wire set_rx = rx_ev & rx_ok & ~flags_q[card_flags_pkg::IDX_RX_FULL];
    // reception onto a full holding register
    wire set_ovr = rx_ev & flags_q[card_flags_pkg::IDX_RX_FULL];
    // low error signal sampled from the card
    wire set_err = card_on & err_sample & ~line_level_q;
    wire [3:0] set_vec = {set_tx, set_rx, set_ovr, set_err};

    // Status fields in bus order, low bits read as zero.
    wire [31:0] status_word = {24'h000000, flags_q, 4'h0};
    wire [3:0] wr_flag_bits = pwdata[card_flags_pkg::BIT_TX_EMPTY:
                                     card_flags_pkg::BIT_ERR_SIG];

    // ****************************************
    // Per-flag clear and arm logic.
    // ****************************************
    // Each flag follows the same read-one, write-zero discipline, so one
    // loop builds them all; the hardware set always wins over any clear.
    logic [3:0] sw_clr; // Qualified software clear per flag.
    logic [3:0] arm_now; // Flag seen as one by a status read.
    genvar gi;
    for (gi = 0; gi < card_flags_pkg::NUM_FLAGS; gi++) begin : g_flag
        // clear needs an earlier read of one
        assign sw_clr[gi] = wr_done & sel_status & ~wr_flag_bits[gi] & armed_q[gi];
        // Arm from the word software was given, not the live flag: a set that
        // lands between setup and access must not arm a clear it never saw.
        assign arm_now[gi] = rd_done & sel_status
                             & prdata_q[card_flags_pkg::BIT_ERR_SIG + gi];
        // Setting the flag anew drops the arm so a stale read cannot clear it.
        assign armed_d[gi] = ~set_vec[gi] & flags_d[gi] & (armed_q[gi] | arm_now[gi]);
    end

    // ****************************************
    // Next flag values.
    // ****************************************
    // Receive enable is deliberately absent here: dropping it keeps flags.
    always_comb begin
        flags_d = flags_q;
        if (sw_clr[card_flags_pkg::IDX_TX_EMPTY] || dma_tx_clr) begin
            flags_d[card_flags_pkg::IDX_TX_EMPTY] = 1'b0;
        end
        if (set_tx || !tx_en) begin
            flags_d[card_flags_pkg::IDX_TX_EMPTY] = 1'b1;
        end
        // rx full untouched by receive enable
        if (sw_clr[card_flags_pkg::IDX_RX_FULL] || dma_rx_clr) begin
            flags_d[card_flags_pkg::IDX_RX_FULL] = 1'b0;
        end
        if (set_rx) begin
            flags_d[card_flags_pkg::IDX_RX_FULL] = 1'b1;
        end
        if (sw_clr[card_flags_pkg::IDX_OVERRUN]) begin
            flags_d[card_flags_pkg::IDX_OVERRUN] = 1'b0;
        end
        if (set_ovr) begin
            flags_d[card_flags_pkg::IDX_OVERRUN] = 1'b1;
        end
        if (sw_clr[card_flags_pkg::IDX_ERR_SIG]) begin
            flags_d[card_flags_pkg::IDX_ERR_SIG] = 1'b0;
        end
        if (set_err) begin
            flags_d[card_flags_pkg::IDX_ERR_SIG] = 1'b1;
        end
    end

    // ****************************************
    // Sticky interrupt events.
    // ****************************************
    // Write one to clear; an event in the same cycle keeps its bit set.
    wire [3:0] istat_clr = (wr_done & sel_istat) ? pwdata[3:0] : 4'h0;
    assign irq_stat_d = (irq_stat_q & ~istat_clr) | set_vec;

    // ****************************************
    // Read data selection.
    // ****************************************
    logic [31:0] rd_mux; // Read word for the addressed register.
    always_comb begin
        rd_mux = 32'h00000000;
        if (sel_status) begin
            rd_mux = status_word;
        end else if (sel_control) begin
            rd_mux = {30'h00000000, control_q};
        end else if (sel_card) begin
            rd_mux = {31'h00000000, card_mode_q};
        end else if (sel_tx) begin
            rd_mux[DATA_W-1:0] = tx_hold_q;
        end else if (sel_rx) begin
            rd_mux[DATA_W-1:0] = rx_hold_q;
        end else if (sel_istat) begin
            rd_mux = {28'h0000000, irq_stat_q};
        end else if (sel_imask) begin
            rd_mux = {28'h0000000, irq_mask_q};
        end
    end

    // ****************************************
    // Pin synchroniser.
    // ****************************************
    // Three stages; the first is read only by the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_sync_q <= '1;
        end else begin
            line_sync_q <= {line_sync_q[SYNC_STAGES_W-2:0], card_line};
        end
    end

    // A change is accepted only once the last two stages agree, which
    // filters a one-cycle glitch at the cost of a cycle of latency.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_level_q <= 1'b1;
        end else if (line_sync_q[SYNC_STAGES_W-1] == line_sync_q[SYNC_STAGES_W-2]) begin
            line_level_q <= line_sync_q[SYNC_STAGES_W-1];
        end
    end

    // ****************************************
    // Flag and arm registers.
    // ****************************************
    // transmit empty starts set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= card_flags_pkg::FLAGS_RESET;
            armed_q <= 4'h0;
        end else begin
            flags_q <= flags_d;
            armed_q <= armed_d;
        end
    end

    // ****************************************
    // Control registers.
    // ****************************************
    // Software owns the enables, card mode and event mask.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= card_flags_pkg::CONTROL_RESET;
            card_mode_q <= 1'b0;
            irq_mask_q <= card_flags_pkg::IRQ_MASK_RESET;
        end else if (wr_done) begin
            if (sel_control) begin
                control_q <= pwdata[1:0];
            end
            if (sel_card) begin
                card_mode_q <= pwdata[card_flags_pkg::BIT_CARD_MODE];
            end
            if (sel_imask) begin
                irq_mask_q <= pwdata[3:0];
            end
        end
    end

    // ****************************************
    // Holding registers.
    // ****************************************
    // The DMA write takes priority over a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_hold_q <= '0;
        end else if (dma_tx_clr) begin
            tx_hold_q <= dma_tx_data;
        end else if (wr_done && sel_tx) begin
            tx_hold_q <= pwdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold_q <= '0;
        end else if (set_rx) begin
            rx_hold_q <= rx_shift_reg;
        end
    end

    // ****************************************
    // Events and outputs.
    // ****************************************
    // All outputs of this block come from flip-flops fed by next-state values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 4'h0;
            irq_q <= 1'b0;
            tx_irq_q <= 1'b0;
            rx_irq_q <= 1'b0;
            rx_allow_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_mask_q);
            // The DMA requests follow the flags only in card mode; the transmit one also needs TE.
            tx_irq_q <= card_on & tx_en & flags_d[card_flags_pkg::IDX_TX_EMPTY];
            rx_irq_q <= card_on & flags_d[card_flags_pkg::IDX_RX_FULL];
            rx_allow_q <= card_on & rx_en & ~flags_d[card_flags_pkg::IDX_OVERRUN];
        end
    end

    // ****************************************
    // APB answer.
    // ****************************************
    // The answer is built in setup, so every access ends after one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            pready_q <= 1'b1;
            pslverr_q <= ~mapped;
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_data = tx_hold_q;
    assign rx_holding_reg = rx_hold_q;
    assign rx_start_allow = rx_allow_q;
    assign tx_empty_irq = tx_irq_q;
    assign rx_full_irq = rx_irq_q;
    assign irq = irq_q;
endmodule

// *** tb/card_status_flags_monitor.sv ***
// Port checker for the smart card status flag block.
`timescale 1ns/10ps
module card_status_flags_monitor #(
    parameter int DATA_W = 8 // Character width.
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_shift_load,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic rx_done,
    input wire logic rx_ok,
    input wire logic [DATA_W-1:0] rx_shift_reg,
    input wire logic [DATA_W-1:0] rx_holding_reg,
    input wire logic rx_start_allow,
    input wire logic dma_tx_wr,
    input wire logic [DATA_W-1:0] dma_tx_data,
    input wire logic dma_rx_rd,
    input wire logic tx_empty_irq,
    input wire logic rx_full_irq
);
    // ****************************************
    // Bus and flag relations.
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // A setup cycle of the bus.
    sequence s_setup;
        psel && !penable;
    endsequence
    // A clean character arriving while reception is allowed.
    sequence s_rx_arrive;
        rx_done && rx_ok && rx_start_allow;
    endsequence
    property p_ready;
        s_setup |=> pready;
    endproperty
    property p_ready_one;
        pready |=> !pready;
    endproperty
    property p_slverr;
        pslverr |-> pready && (prdata == 32'h0);
    endproperty
    // Simultaneous bus traffic is excluded since set and clear would race.
    property p_rx_load;
        s_rx_arrive ##0 (!rx_full_irq && !psel)
            |=> rx_full_irq && (rx_holding_reg == $past(rx_shift_reg));
    endproperty
    property p_overrun;
        s_rx_arrive ##0 (rx_full_irq && !dma_rx_rd && !psel)
            |=> $stable(rx_holding_reg) && !rx_start_allow;
    endproperty
    property p_blocked;
        rx_done && !rx_start_allow |=> $stable(rx_holding_reg);
    endproperty
    property p_dma_tx;
        dma_tx_wr && tx_empty_irq && !tx_shift_load && !psel
            |=> !tx_empty_irq && (tx_data == $past(dma_tx_data));
    endproperty
    property p_dma_rx;
        dma_rx_rd && rx_full_irq && !rx_done |=> !rx_full_irq;
    endproperty
    a_ready: assert property (p_ready) else $error("pready missing after setup");
    a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
    a_slverr: assert property (p_slverr) else $error("bad error response");
    a_rx_load: assert property (p_rx_load) else $error("character not loaded");
    a_overrun: assert property (p_overrun) else $error("overrun not handled");
    a_blocked: assert property (p_blocked) else $error("refused reception loaded");
    a_dma_tx: assert property (p_dma_tx) else $error("dma write not taken");
    a_dma_rx: assert property (p_dma_rx) else $error("dma read did not clear");
endmodule

bind card_status_flags card_status_flags_monitor #(.DATA_W(DATA_W)) i_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_shift_load(tx_shift_load), .tx_data(tx_data),
    .rx_done(rx_done), .rx_ok(rx_ok), .rx_shift_reg(rx_shift_reg),
    .rx_holding_reg(rx_holding_reg), .rx_start_allow(rx_start_allow),
    .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data), .dma_rx_rd(dma_rx_rd),
    .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq));

// *** tb/card_model.sv ***
// Behavioural smart card with its receive framer.
`timescale 1ns/10ps
module card_model (
    input wire logic pclk,
    output logic card_line,
    output logic rx_done,
    output logic rx_ok,
    output logic [7:0] rx_shift_reg,
    output logic err_sample
);
    // ****************************************
    // Line and reception events.
    // ****************************************
    initial begin
        card_line = 1'b1;
        rx_done = 1'b0;
        rx_ok = 1'b0;
        rx_shift_reg = 8'h00;
        err_sample = 1'b0;
    end
    // One finished character; data is scrambled once no longer valid.
    task automatic send_char(input logic [7:0] d, input logic ok);
        @(posedge pclk);
        rx_done <= 1'b1;
        rx_ok <= ok;
        rx_shift_reg <= d;
        @(posedge pclk);
        rx_done <= 1'b0;
        rx_ok <= 1'b0;
        rx_shift_reg <= ~d;
    endtask
    // low error signal
    // The line is held low long enough for the pin filter to accept it.
    task automatic signal_error();
        @(posedge pclk);
        card_line <= 1'b0;
        repeat (8) @(posedge pclk);
        err_sample <= 1'b1;
        @(posedge pclk);
        err_sample <= 1'b0;
        repeat (2) @(posedge pclk);
        card_line <= 1'b1;
    endtask
endmodule

// *** tb/smart_card_serial_status_flags_tb.sv ***
// Self-checking bench for the smart card status flag block.
`timescale 1ns/10ps
module smart_card_serial_status_flags_tb;
    // ****************************************
    // Signals and expected status bits.
    // ****************************************
    localparam logic [31:0] S_TX = 32'h1 << card_flags_pkg::BIT_TX_EMPTY;
    localparam logic [31:0] S_RX = 32'h1 << card_flags_pkg::BIT_RX_FULL;
    localparam logic [31:0] S_OV = 32'h1 << card_flags_pkg::BIT_OVERRUN;
    localparam logic [31:0] S_ER = 32'h1 << card_flags_pkg::BIT_ERR_SIG;
    localparam logic [31:0] M_RX = 32'h1 << card_flags_pkg::IDX_RX_FULL;
    localparam logic [7:0] ST = card_flags_pkg::OFF_STATUS;
    localparam logic [7:0] CTL = card_flags_pkg::OFF_CONTROL;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0] paddr = 8'h00, dma_tx_data = 8'h00, tx_data, rx_shift_reg, rx_holding_reg;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic tx_shift_load = 1'b0, dma_tx_wr = 1'b0, dma_rx_rd = 1'b0;
    logic pready, pslverr, rx_done, rx_ok, rx_start_allow, card_line, err_sample;
    logic tx_empty_irq, rx_full_irq, irq;
    int err_total = 0;
    int checks_done = 0;
    // Half period of the 200 MHz clock.
    always #2.5 pclk = ~pclk;
    card_status_flags #(.DATA_W(8)) i_card_status_flags (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_shift_load(tx_shift_load), .tx_data(tx_data), .rx_done(rx_done), .rx_ok(rx_ok),
        .rx_shift_reg(rx_shift_reg), .rx_holding_reg(rx_holding_reg),
        .rx_start_allow(rx_start_allow), .card_line(card_line), .err_sample(err_sample),
        .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data), .dma_rx_rd(dma_rx_rd),
        .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .irq(irq));
    card_model i_card_model (.pclk(pclk), .card_line(card_line), .rx_done(rx_done),
        .rx_ok(rx_ok), .rx_shift_reg(rx_shift_reg), .err_sample(err_sample));
    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 64) err_total++;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check($sformatf("register %h", a), rdv & m, exp);
    endtask
    // Read first so that the following zero write counts as a clear.
    task automatic clr(input logic [31:0] m);
        apb(1'b0, ST, 32'h0);
        apb(1'b1, ST, ~m);
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic dma_rd();
        @(posedge pclk);
        dma_rx_rd <= 1'b1;
        @(posedge pclk);
        dma_rx_rd <= 1'b0;
    endtask
    task automatic shift_load();
        @(posedge pclk);
        tx_shift_load <= 1'b1;
        @(posedge pclk);
        tx_shift_load <= 1'b0;
    endtask
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset();
        rdc(ST, 32'hFFFFFFFF, S_TX);
        rdc(CTL, 32'hFFFFFFFF, 32'h0);
        rdc(card_flags_pkg::OFF_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped error", {31'h0, er}, 32'h1);
        check("unmapped data", rdv, 32'h0);
    endtask
    // Without card mode a character must leave the flags alone.
    task automatic t_mode_off();
        apb(1'b1, CTL, 32'h3);
        i_card_model.send_char(8'h5A, 1'b1);
        settle();
        rdc(ST, 32'hF0, S_TX);
        check("start allow", rx_start_allow, 32'h0);
        apb(1'b1, card_flags_pkg::OFF_CARD_MODE, 32'h1);
    endtask
    task automatic t_tx();
        clr(S_TX);
        rdc(ST, 32'hF0, 32'h0);
        shift_load();
        apb(1'b1, ST, 32'h0);
        rdc(ST, 32'hF0, S_TX);
        apb(1'b1, ST, 32'hFF);
        rdc(ST, 32'hF0, S_TX);
        apb(1'b1, ST, 32'h0);
        rdc(ST, 32'hF0, 32'h0);
        shift_load();
        settle();
        @(posedge pclk);
        dma_tx_wr <= 1'b1;
        dma_tx_data <= 8'h3C;
        @(posedge pclk);
        dma_tx_wr <= 1'b0;
        settle();
        check("tx data", tx_data, 32'h3C);
        rdc(card_flags_pkg::OFF_TX_DATA, 32'hFF, 32'h3C);
        rdc(ST, 32'hF0, 32'h0);
        apb(1'b1, CTL, 32'h2);
        rdc(ST, 32'hF0, S_TX);
        apb(1'b1, CTL, 32'h3);
    endtask
    task automatic t_rx();
        i_card_model.send_char(8'hA5, 1'b1);
        settle();
        check("holding", rx_holding_reg, 32'hA5);
        i_card_model.send_char(8'hC3, 1'b1);
        settle();
        check("holding kept", rx_holding_reg, 32'hA5);
        check("start allow", rx_start_allow, 32'h0);
        rdc(ST, 32'h70, S_RX | S_OV);
        i_card_model.send_char(8'h99, 1'b1);
        settle();
        check("holding refused", rx_holding_reg, 32'hA5);
        rdc(card_flags_pkg::OFF_RX_DATA, 32'hFF, 32'hA5);
        apb(1'b1, CTL, 32'h1);
        rdc(ST, 32'h70, S_RX | S_OV);
        apb(1'b1, CTL, 32'h3);
        clr(S_RX | S_OV);
        rdc(ST, 32'h70, 32'h0);
        check("start allow", rx_start_allow, 32'h1);
    endtask
    task automatic t_dma_err();
        i_card_model.send_char(8'h11, 1'b1);
        settle();
        check("rx request", rx_full_irq, 32'h1);
        dma_rd();
        rdc(ST, 32'h70, 32'h0);
        i_card_model.send_char(8'h22, 1'b0);
        rdc(ST, 32'h70, 32'h0);
        i_card_model.signal_error();
        rdc(ST, 32'h70, S_ER);
        clr(S_ER);
        rdc(ST, 32'h70, 32'h0);
    endtask
    task automatic t_irq();
        apb(1'b1, card_flags_pkg::OFF_IRQ_STATUS, 32'hF);
        apb(1'b1, card_flags_pkg::OFF_IRQ_MASK, M_RX);
        i_card_model.send_char(8'h44, 1'b1);
        settle();
        check("irq raised", irq, 32'h1);
        dma_rd();
        apb(1'b1, card_flags_pkg::OFF_IRQ_STATUS, M_RX);
        apb(1'b1, card_flags_pkg::OFF_IRQ_MASK, 32'h0);
        i_card_model.send_char(8'h55, 1'b1);
        settle();
        check("irq masked", irq, 32'h0);
        rdc(card_flags_pkg::OFF_IRQ_STATUS, 32'hF, M_RX);
    endtask
    // ****************************************
    // Sequence, watchdog and verdict.
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mode_off();
        t_tx();
        t_rx();
        t_dma_err();
        t_irq();
        complete_run();
    end
    // The tests need under two thousand cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        complete_run();
    end
endmodule
